// ### pnc_defines.svh
`ifndef PNC_DEFINES_SVH
`define PNC_DEFINES_SVH

// Register offsets
`define PNC_OFS_ORDER0    8'h4A
`define PNC_OFS_ORDER1    8'h4B
`define PNC_OFS_ORDER2    8'h4C
`define PNC_OFS_ORDER3    8'h4D
`define PNC_OFS_ORDER4    8'h4E
`define PNC_OFS_SAT       8'h50

// Reset values
`define PNC_RST_ORDER1    16'h0407
`define PNC_RST_ORDER2    16'hF23E
`define PNC_RST_ORDER3    16'h1144
`define PNC_RST_ORDER4    16'hF881
`define PNC_RST_SAT       24'h200100
`define PNC_SAT_RSVD_VAL  18'h20010

// Field positions in the order-zero register
`define PNC_BIT_NL_ON     0
`define PNC_LSB_ORDER0    2
`define PNC_MSB_ORDER0    17
`define PNC_LSB_SCALE     18
`define PNC_MSB_SCALE     19

// Widths
`define PNC_REG_W         24
`define PNC_COEF_W        16
`define PNC_NUM_STEPS     4

`endif

// ### pnc_pkg.sv
package pnc_pkg;

  // Correction terms supplied by neighbouring pipeline stages
  typedef struct packed {
    logic [15:0] offset;
    logic [15:0] temp;
    logic [15:0] freq;
  } pnc_corr_t;

  // Saturation-control register layout
  typedef struct packed {
    logic        rsvd_hi;
    logic        dealias_manual_override;
    logic [17:0] rsvd;
    logic [3:0]  step_saturate;
  } pnc_sat_ctrl_t;

  // Unwrap setting pair
  typedef struct packed {
    logic [1:0] unwrap_frequency_select;
    logic       unwrap_enable;
  } pnc_unwrap_t;

endpackage

// ### pnc_phase_step.sv
`timescale 1ns/1ps
`include "pnc_defines.svh"

module pnc_phase_step import pnc_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset, for checking only
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Step datapath
  input  wire logic [W-1:0] phase_in,
  input  wire logic [W-1:0] corr,
  input  wire logic         saturate,
  output logic      [W-1:0] phase_out
);

  localparam logic [W+1:0] MAX_PHASE = {2'b00, {W{1'b1}}};

  logic signed [W+1:0] sum;

  // Unsigned phase plus signed correction, two guard bits
  assign sum = $signed({2'b00, phase_in}) + $signed({{2{corr[W-1]}}, corr});

  always_comb begin
    if (!saturate) begin
      phase_out = sum[W-1:0];
    end else if (sum < 0) begin
      phase_out = '0;
    end else if (sum > $signed(MAX_PHASE)) begin
      phase_out = {W{1'b1}};
    end else begin
      phase_out = sum[W-1:0];
    end
  end

  property p_wrap;
    @(posedge mclk) disable iff (!rst_n)
      !saturate |-> phase_out == W'(phase_in + corr);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap step result not modulo sum");

  property p_clip_low;
    @(posedge mclk) disable iff (!rst_n)
      (saturate && corr[W-1] && ({1'b0, phase_in} < {1'b0, -corr}))
        |-> phase_out == '0;
  endproperty
  a_clip_low: assert property (p_clip_low)
    else $error("clip step did not hold at minimum");

  property p_clip_high;
    @(posedge mclk) disable iff (!rst_n)
      (saturate && !corr[W-1] && ({1'b0, phase_in} + {1'b0, corr} > MAX_PHASE))
        |-> phase_out == {W{1'b1}};
  endproperty
  a_clip_high: assert property (p_clip_high)
    else $error("clip step did not hold at maximum");

endmodule // pnc_phase_step

// ### pnc_phase_corr.sv
// How it works
// - First-order coefficient, 16 bits read-write, resets to 0407h.
// - Second-order coefficient, 16 bits read-write, resets to F23Eh.
// - Third-order coefficient, 16 bits read-write, resets to 1144h.
// - Fourth-order coefficient, 16 bits read-write, resets to F881h.
// - Coefficient bits 23:16 read zero; host writes zero there.
// - Offset step wraps when bit 3 is low, clips when high.
// - Temperature step wraps when bit 2 is low, clips when high.
// - Nonlinearity step wraps when bit 1 is low, clips when high.
// - Frequency step wraps when bit 0 is low, clips when high.
// - Bit 22 set lets host drive unwrap frequency and enable directly.
// - Saturation control resets to 200100h: all wrap, override clear.
// - Harmonic correction applies only while the enable bit is set.
// - Two-bit scale field scales every nonlinearity coefficient.
// - Zeroth-order coefficient completes the correction polynomial.
`timescale 1ns/1ps
`include "pnc_defines.svh"

module pnc_phase_corr import pnc_pkg::*; (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  // Decoded register access from the serial control interface
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [`PNC_REG_W-1:0]   reg_wdata,
  output logic      [`PNC_REG_W-1:0]   reg_rdata,
  // Phase pipeline
  input  wire logic                    phase_valid,
  input  wire logic [15:0]             phase_in,
  input  wire pnc_corr_t               corr_in,
  output logic                         phase_out_valid,
  output logic      [15:0]             phase_out,
  // Unwrap settings
  input  wire pnc_unwrap_t             unwrap_auto,
  input  wire pnc_unwrap_t             unwrap_manual,
  output pnc_unwrap_t                  unwrap_out
);

  localparam int NS = `PNC_NUM_STEPS;
  localparam int CW = `PNC_COEF_W;
  localparam logic [CW-1:0] COEF_RST [1:4] = '{
    `PNC_RST_ORDER1, `PNC_RST_ORDER2, `PNC_RST_ORDER3, `PNC_RST_ORDER4};
  localparam logic [7:0] COEF_OFS [1:4] = '{
    `PNC_OFS_ORDER1, `PNC_OFS_ORDER2, `PNC_OFS_ORDER3, `PNC_OFS_ORDER4};

  logic                rst_meta;
  logic                rst_n_sync;
  logic [CW-1:0]       nl_coef [0:4];
  logic [1:0]          linearity_coeff_scale;
  logic                linearity_correction_on;
  pnc_sat_ctrl_t       sat_ctrl;
  logic [15:0]         stage [0:NS];
  logic [15:0]         step_corr [0:NS-1];
  logic [CW-1:0]       nl_term;
  logic [`PNC_REG_W-1:0] next_reg_rdata;

  // Reset released through two flops; the first is read only by the second
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  // Order-zero register: enable, scale, zeroth-order coefficient
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      nl_coef[0]              <= '0;
      linearity_coeff_scale   <= 2'h0;
      linearity_correction_on <= 1'b0;
    end else if (reg_wr && reg_addr == `PNC_OFS_ORDER0) begin
      nl_coef[0] <= reg_wdata[`PNC_MSB_ORDER0:`PNC_LSB_ORDER0];
      linearity_coeff_scale <=
        reg_wdata[`PNC_MSB_SCALE:`PNC_LSB_SCALE];
      linearity_correction_on <= reg_wdata[`PNC_BIT_NL_ON];
    end
  end

  // Coefficients of orders one to four; upper bits are not stored
  for (genvar k = 1; k <= 4; k++) begin : g_coef
    always_ff @(posedge mclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
        nl_coef[k] <= COEF_RST[k];
      end else if (reg_wr && reg_addr == COEF_OFS[k]) begin
        nl_coef[k] <= reg_wdata[CW-1:0];
      end
    end
  end

  // Saturation control; reserved bits kept as written so they read back
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sat_ctrl <= `PNC_RST_SAT;
    end else if (reg_wr && reg_addr == `PNC_OFS_SAT) begin
      sat_ctrl <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    next_reg_rdata = '0;
    if (reg_addr == `PNC_OFS_ORDER0) begin
      next_reg_rdata[`PNC_MSB_SCALE:`PNC_LSB_SCALE] = linearity_coeff_scale;
      next_reg_rdata[`PNC_MSB_ORDER0:`PNC_LSB_ORDER0] = nl_coef[0];
      next_reg_rdata[`PNC_BIT_NL_ON] = linearity_correction_on;
    end else if (reg_addr == `PNC_OFS_ORDER1) begin
      next_reg_rdata = {8'h00, nl_coef[1]};
    end else if (reg_addr == `PNC_OFS_ORDER2) begin
      next_reg_rdata = {8'h00, nl_coef[2]};
    end else if (reg_addr == `PNC_OFS_ORDER3) begin
      next_reg_rdata = {8'h00, nl_coef[3]};
    end else if (reg_addr == `PNC_OFS_ORDER4) begin
      next_reg_rdata = {8'h00, nl_coef[4]};
    end else if (reg_addr == `PNC_OFS_SAT) begin
      next_reg_rdata = sat_ctrl;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Horner polynomial over the frequency-corrected phase as a fraction.
  // Intermediate sums wrap at 16 bits; coefficients must keep it in range.
  function automatic logic [CW-1:0] horner_step(
    input logic [CW-1:0] acc,
    input logic [CW-1:0] coef,
    input logic [15:0]   x
  );
    logic signed [CW+16:0] prod;
    prod = $signed(acc) * $signed({1'b0, x});
    return CW'(prod >>> 16) + coef;
  endfunction

  always_comb begin
    logic [CW-1:0] acc;
    acc = nl_coef[4];
    for (int k = 3; k >= 0; k--) begin
      acc = horner_step(acc, nl_coef[k], stage[1]);
    end
    acc = acc << linearity_coeff_scale;
    nl_term = linearity_correction_on ? acc : '0;
  end

  assign stage[0]     = phase_in;
  assign step_corr[0] = corr_in.freq;
  assign step_corr[1] = nl_term;
  assign step_corr[2] = corr_in.temp;
  assign step_corr[3] = corr_in.offset;

  // Selector bit i governs step i: freq, linearity, temp, offset
  for (genvar i = 0; i < NS; i++) begin : g_step
    pnc_phase_step #(
      .W (16)
    ) u_step (
      .mclk      (mclk),
      .rst_n     (rst_n_sync),
      .phase_in  (stage[i]),
      .corr      (step_corr[i]),
      .saturate  (sat_ctrl.step_saturate[i]),
      .phase_out (stage[i+1])
    );
  end

  // One register stage keeps the long adder chain off the output pins
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      phase_out_valid <= 1'b0;
      phase_out       <= '0;
    end else begin
      phase_out_valid <= phase_valid;
      if (phase_valid) begin
        phase_out <= stage[NS];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      unwrap_out <= '0;
    end else if (sat_ctrl.dealias_manual_override) begin
      unwrap_out <= unwrap_manual;
    end else begin
      unwrap_out <= unwrap_auto;
    end
  end

  property p_sat_reset;
    @(posedge mclk) $rose(rst_n_sync) |-> sat_ctrl == `PNC_RST_SAT;
  endproperty
  a_sat_reset: assert property (p_sat_reset)
    else $error("saturation control not at reset value");

  property p_coef_reset;
    @(posedge mclk) $rose(rst_n_sync) |-> nl_coef[1] == `PNC_RST_ORDER1 &&
      nl_coef[2] == `PNC_RST_ORDER2 && nl_coef[3] == `PNC_RST_ORDER3 &&
      nl_coef[4] == `PNC_RST_ORDER4;
  endproperty
  a_coef_reset: assert property (p_coef_reset)
    else $error("coefficient not at reset value");

  property p_coef_upper_zero;
    @(posedge mclk) disable iff (!rst_n_sync)
      (reg_rd && reg_addr >= `PNC_OFS_ORDER1 && reg_addr <= `PNC_OFS_ORDER4)
        |=> reg_rdata[23:16] == 8'h00;
  endproperty
  a_coef_upper_zero: assert property (p_coef_upper_zero)
    else $error("coefficient upper bits read nonzero");

  property p_coef_readback;
    @(posedge mclk) disable iff (!rst_n_sync)
      (reg_wr && reg_addr == `PNC_OFS_ORDER2) ##1 !reg_wr ##1
      (reg_rd && !reg_wr && reg_addr == `PNC_OFS_ORDER2)
        |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3);
  endproperty
  a_coef_readback: assert property (p_coef_readback)
    else $error("second-order coefficient read back differs");

  property p_nl_off;
    @(posedge mclk) disable iff (!rst_n_sync)
      !linearity_correction_on |-> stage[2] == stage[1] || sat_ctrl[1];
  endproperty
  a_nl_off: assert property (p_nl_off)
    else $error("linearity step altered phase while disabled");

  property p_override;
    @(posedge mclk) disable iff (!rst_n_sync)
      sat_ctrl.dealias_manual_override |=> unwrap_out == $past(unwrap_manual);
  endproperty
  a_override: assert property (p_override)
    else $error("manual unwrap settings not passed through");

  property p_auto;
    @(posedge mclk) disable iff (!rst_n_sync)
      !sat_ctrl.dealias_manual_override |=> unwrap_out == $past(unwrap_auto);
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic unwrap settings not passed through");

  property p_phase_latency;
    @(posedge mclk) disable iff (!rst_n_sync)
      phase_valid |=> phase_out_valid && phase_out == $past(stage[NS]);
  endproperty
  a_phase_latency: assert property (p_phase_latency)
    else $error("corrected phase not presented one cycle later");

endmodule // pnc_phase_corr

// ### pnc_host_model.sv
`timescale 1ns/1ps
`include "pnc_defines.svh"

module pnc_host_model (
  // Clock
  input  wire logic        mclk,
  // Decoded register port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [23:0]      reg_wdata,
  input  wire logic [23:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 24'h000000;
  end

  // Released bus shows inverted values, never the stale word
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask

  // Reserved field always carries its fixed pattern, bit 23 zero
  task automatic wr_sat(input logic ovr, input logic [3:0] clip);
    wr(`PNC_OFS_SAT, {1'b0, ovr, `PNC_SAT_RSVD_VAL, clip});
  endtask
endmodule // pnc_host_model

// ### tb_top.sv
`timescale 1ns/1ps
`include "pnc_defines.svh"

module tb_top import pnc_pkg::*; ;
  logic        mclk;
  logic        resetn;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [23:0] reg_wdata;
  logic [23:0] reg_rdata;
  logic        phase_valid;
  logic        phase_out_valid;
  logic [15:0] phase_in;
  logic [15:0] phase_out;
  pnc_corr_t   corr_in;
  pnc_unwrap_t unwrap_auto;
  pnc_unwrap_t unwrap_manual;
  pnc_unwrap_t unwrap_out;
  int          n_mismatch;
  int          tests_run;
  int          cycles;

  pnc_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  pnc_phase_corr dut (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .phase_valid(phase_valid),
    .phase_in(phase_in), .corr_in(corr_in),
    .phase_out_valid(phase_out_valid), .phase_out(phase_out),
    .unwrap_auto(unwrap_auto), .unwrap_manual(unwrap_manual),
    .unwrap_out(unwrap_out));

  always #5 mclk = ~mclk;

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [23:0] exp);
    logic [23:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask

  // One phase sample; result is due exactly one edge later
  task automatic run_phase(input logic [15:0] p, input pnc_corr_t c,
                           input logic [15:0] exp);
    @(posedge mclk);
    #1;
    phase_in = p;
    corr_in = c;
    phase_valid = 1'b1;
    @(posedge mclk);
    #1;
    phase_valid = 1'b0;
    check({7'h00, phase_out_valid, phase_out}, {8'h01, exp});
  endtask

  task automatic t_reset;
    rd_check(`PNC_OFS_ORDER1, 24'h000407);
    rd_check(`PNC_OFS_ORDER2, 24'h00F23E);
    rd_check(`PNC_OFS_ORDER3, 24'h001144);
    rd_check(`PNC_OFS_ORDER4, 24'h00F881);
    rd_check(`PNC_OFS_SAT, 24'h200100);
    rd_check(`PNC_OFS_ORDER0, 24'h000000);
    rd_check(8'h4F, 24'h000000);
  endtask

  // Upper byte written as ones on purpose; it must not stick
  task automatic t_coeff;
    for (int a = 8'h4B; a <= 8'h4E; a++) begin
      host.wr(8'(a), {8'hFF, 8'(a), 8'h5A});
      rd_check(8'(a), {8'h00, 8'(a), 8'h5A});
    end
  endtask

  // Each step overflows alone; higher coefficients zero so nl = a0
  task automatic t_sat;
    pnc_corr_t cr;
    for (int a = 8'h4B; a <= 8'h4E; a++) host.wr(8'(a), 24'h000000);
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 2; c++) begin
        host.wr_sat(1'b0, 4'(c << i));
        host.wr(`PNC_OFS_ORDER0, (i == 1) ? 24'h01FFFD : 24'h000000);
        cr = '0;
        if (i == 0) cr.freq = 16'h0020;
        if (i == 2) cr.temp = 16'h0020;
        if (i == 3) cr.offset = 16'h0020;
        run_phase(16'hFFF0, cr, (c == 1) ? 16'hFFFF :
          ((i == 1) ? 16'h7FEF : 16'h0010));
      end
    end
    cr = '0;
    cr.offset = 16'hFFE0;
    host.wr_sat(1'b0, 4'h8);
    run_phase(16'h0010, cr, 16'h0000);
    cr.offset = 16'h0000;
    host.wr_sat(1'b0, 4'h0);
    host.wr(`PNC_OFS_ORDER0, 24'h080401);
    rd_check(`PNC_OFS_ORDER0, 24'h080401);
    run_phase(16'h0000, cr, 16'h0400);
    host.wr(`PNC_OFS_ORDER0, 24'h080400);
    run_phase(16'h0000, cr, 16'h0000);
    // Half-scale phase times first-order term 100h adds 80h
    host.wr(`PNC_OFS_ORDER1, 24'h000100);
    host.wr(`PNC_OFS_ORDER0, 24'h000001);
    run_phase(16'h8000, cr, 16'h8080);
  endtask

  task automatic t_override;
    unwrap_auto = 3'b101;
    unwrap_manual = 3'b010;
    host.wr_sat(1'b0, 4'h0);
    repeat (2) @(posedge mclk);
    #1;
    check({21'h0, unwrap_out}, 24'h000005);
    host.wr_sat(1'b1, 4'h0);
    repeat (2) @(posedge mclk);
    #1;
    check({21'h0, unwrap_out}, 24'h000002);
    rd_check(`PNC_OFS_SAT, 24'h600100);
  endtask

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    phase_valid = 1'b0;
    phase_in = 16'h0000;
    corr_in = '0;
    unwrap_auto = 3'b000;
    unwrap_manual = 3'b000;
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    // Internal reset copy needs two more edges
    repeat (3) @(posedge mclk);
    t_reset();
    t_coeff();
    t_sat();
    t_override();
    test_done();
  end
endmodule // tb_top
